// ### design/port_mux_params.svh
// constants for the port output combining block: offsets, resets, tie values
// assumes inclusion by bare name from the design modules
`ifndef PORT_MUX_PARAMS_SVH
`define PORT_MUX_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define PORT_LATCH_OFS        8'h00
`define PORT_DIR_OFS          8'h04
`define PORT_OPEN_DRAIN_OFS   8'h08
`define PORT_ANALOG_OFS       8'h0c
`define PORT_LEVEL_OFS        8'h10

// ****************************************************************
// reset values
// ****************************************************************
`define PORT_LATCH_RESET      8'h00
`define PORT_DIR_RESET        8'hff
`define PORT_OPEN_DRAIN_RESET 8'h00
`define PORT_ANALOG_RESET     8'hff

// ****************************************************************
// encodings and tie levels
// ****************************************************************
`define PORT_DIR_OUTPUT       1'b0
`define PORT_ABSENT_GATE      1'b1
`define PORT_ABSENT_CONTRIB   1'b0
`define PORT_NO_OPEN_DRAIN    1'b0

`endif

// ### design/port_mux_pkg.sv
// types shared by the port output combining block
// assumes port_mux_params.svh is on the include path
`default_nettype none

package port_mux_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } reg_req_t;

  typedef struct packed {
    logic analog_select_bit;
    logic direction_bit;
    logic open_drain_select_bit;
    logic latch;
  } pin_cfg_t;

  typedef struct packed {
    logic drive_value;
    logic drive_oe_n;
    logic digital_in;
  } pin_drive_t;

endpackage

`default_nettype wire

// ### design/pin_output_cell.sv
// combinational output path of one port pin
// assumes the caller registers its results and passes the pin's features as parameters
`include "port_mux_params.svh"
`default_nettype none

module pin_output_cell #(
  parameter bit HAS_SERIAL = 1'b1,
  parameter bit HAS_OTHER  = 1'b1,
  parameter bit HAS_OD     = 1'b1,
  parameter bit HAS_ANALOG = 1'b1
) (
  input  wire port_mux_pkg::pin_cfg_t   cfg,
  input  wire logic                     serial_out,
  input  wire logic                     other_out,
  input  wire logic                     pin_level,
  output var  port_mux_pkg::pin_drive_t drive
);

  wire logic serial_gate;
  wire logic other_contrib;
  wire logic od_ctrl;
  wire logic analog_on;
  wire logic and_stage;
  wire logic or_stage;
  wire logic out_mode;
  wire logic drive_on;

  assign serial_gate   = HAS_SERIAL ? serial_out : `PORT_ABSENT_GATE;
  assign other_contrib = HAS_OTHER ? other_out : `PORT_ABSENT_CONTRIB;
  assign od_ctrl       = HAS_OD ? cfg.open_drain_select_bit : `PORT_NO_OPEN_DRAIN;
  assign analog_on     = HAS_ANALOG ? cfg.analog_select_bit : 1'b0;

  assign and_stage = serial_gate & cfg.latch;
  assign or_stage  = and_stage | other_contrib;

  // analog use parks the digital driver
  assign out_mode = (cfg.direction_bit == `PORT_DIR_OUTPUT) & ~analog_on;
  // open drain only ever pulls low, a high is released to the pull-up
  assign drive_on = out_mode & ~(od_ctrl & or_stage);

  assign drive.drive_value = or_stage;
  assign drive.drive_oe_n  = ~drive_on;
  assign drive.digital_in  = pin_level & ~analog_on;

endmodule

`default_nettype wire

// ### design/port_output_mux_logic.sv
// port register bank and per-pin output combining for one general-purpose port
// assumes a one-cycle register port, peripheral outputs and pin levels synchronous to clock
//
// Design decisions made here: the placing of the registers and the strobed register port.
`include "port_mux_params.svh"
`default_nettype none

module port_output_mux_logic #(
  parameter int                    NUM_PINS    = 8,
  parameter logic [NUM_PINS-1:0]   SERIAL_MASK = '1,
  parameter logic [NUM_PINS-1:0]   OTHER_MASK  = '1,
  parameter logic [NUM_PINS-1:0]   OD_MASK     = '1,
  parameter logic [NUM_PINS-1:0]   ANALOG_MASK = '1
) (
  input  wire logic                         clock,
  input  wire logic                         srst,
  input  wire port_mux_pkg::reg_req_t       bus_req,
  output logic [port_mux_pkg::DATA_W-1:0]   rd_data,
  input  wire logic [NUM_PINS-1:0]          serial_out,
  input  wire logic [NUM_PINS-1:0]          other_out,
  input  wire logic [NUM_PINS-1:0]          pin_in,
  output logic [NUM_PINS-1:0]               pin_out,
  output logic [NUM_PINS-1:0]               pin_oe_n,
  output logic [NUM_PINS-1:0]               digital_in,
  output logic [NUM_PINS-1:0]               analog_en
);

  // ****************************************************************
  // register decode
  // ****************************************************************
  localparam logic [NUM_PINS-1:0] LATCH_RST  = NUM_PINS'(`PORT_LATCH_RESET);
  localparam logic [NUM_PINS-1:0] DIR_RST    = NUM_PINS'(`PORT_DIR_RESET);
  localparam logic [NUM_PINS-1:0] OD_RST     = NUM_PINS'(`PORT_OPEN_DRAIN_RESET) & OD_MASK;
  localparam logic [NUM_PINS-1:0] ANALOG_RST = NUM_PINS'(`PORT_ANALOG_RESET) & ANALOG_MASK;

  logic [NUM_PINS-1:0]              latch_reg;
  logic [NUM_PINS-1:0]              dir_reg;
  logic [NUM_PINS-1:0]              od_reg;
  logic [NUM_PINS-1:0]              analog_reg;
  logic [NUM_PINS-1:0]              level_reg;
  logic [port_mux_pkg::DATA_W-1:0]  rd_data_reg;
  logic [NUM_PINS-1:0]              pin_out_reg;
  logic [NUM_PINS-1:0]              pin_oe_n_reg;
  logic [NUM_PINS-1:0]              digital_in_reg;

  wire logic [NUM_PINS-1:0]              wdata_pins;
  wire logic                             wr_latch;
  wire logic                             wr_dir;
  wire logic                             wr_od;
  wire logic                             wr_analog;
  wire logic [NUM_PINS-1:0]              latch_next;
  wire logic [NUM_PINS-1:0]              dir_next;
  wire logic [NUM_PINS-1:0]              od_next;
  wire logic [NUM_PINS-1:0]              analog_next;
  wire logic [port_mux_pkg::DATA_W-1:0]  rd_mux;
  wire logic [port_mux_pkg::DATA_W-1:0]  rd_data_next;
  wire logic [NUM_PINS-1:0]              cell_value;
  wire logic [NUM_PINS-1:0]              cell_oe_n;
  wire logic [NUM_PINS-1:0]              cell_din;

  assign wdata_pins = bus_req.wdata[NUM_PINS-1:0];
  assign wr_latch   = bus_req.we && (bus_req.addr == `PORT_LATCH_OFS);
  assign wr_dir     = bus_req.we && (bus_req.addr == `PORT_DIR_OFS);
  assign wr_od      = bus_req.we && (bus_req.addr == `PORT_OPEN_DRAIN_OFS);
  assign wr_analog  = bus_req.we && (bus_req.addr == `PORT_ANALOG_OFS);

  assign latch_next  = wr_latch ? wdata_pins : latch_reg;
  assign dir_next    = wr_dir ? wdata_pins : dir_reg;
  // bits for missing features cannot be set, so they read back as zero
  assign od_next     = wr_od ? (wdata_pins & OD_MASK) : od_reg;
  assign analog_next = wr_analog ? (wdata_pins & ANALOG_MASK) : analog_reg;

  // unmapped addresses read as zero, never stall
  assign rd_mux =
    (bus_req.addr == `PORT_LATCH_OFS)      ? port_mux_pkg::DATA_W'(latch_reg)  :
    (bus_req.addr == `PORT_DIR_OFS)        ? port_mux_pkg::DATA_W'(dir_reg)    :
    (bus_req.addr == `PORT_OPEN_DRAIN_OFS) ? port_mux_pkg::DATA_W'(od_reg)     :
    (bus_req.addr == `PORT_ANALOG_OFS)     ? port_mux_pkg::DATA_W'(analog_reg) :
    (bus_req.addr == `PORT_LEVEL_OFS)      ? port_mux_pkg::DATA_W'(level_reg)  :
    '0;
  // data stand only in the cycle after the read strobe
  assign rd_data_next = bus_req.re ? rd_mux : '0;

  // ****************************************************************
  // register bank
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      latch_reg  <= LATCH_RST;
      dir_reg    <= DIR_RST;
      od_reg     <= OD_RST;
      analog_reg <= ANALOG_RST;
    end else begin
      latch_reg  <= latch_next;
      dir_reg    <= dir_next;
      od_reg     <= od_next;
      analog_reg <= analog_next;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rd_data_reg <= '0;
      level_reg   <= '0;
    end else begin
      rd_data_reg <= rd_data_next;
      level_reg   <= pin_in;
    end
  end

  // ****************************************************************
  // per-pin combining
  // ****************************************************************
  // a peripheral that leaves its unused output high would force the pin;
  // the OR stage trusts software to park such outputs low
  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i = i + 1) begin : g_pin
      wire port_mux_pkg::pin_cfg_t   cfg;
      wire port_mux_pkg::pin_drive_t drive;

      assign cfg.analog_select_bit     = analog_reg[i];
      assign cfg.direction_bit         = dir_reg[i];
      assign cfg.open_drain_select_bit = od_reg[i];
      assign cfg.latch                 = latch_reg[i];

      pin_output_cell #(
        .HAS_SERIAL (SERIAL_MASK[i]),
        .HAS_OTHER  (OTHER_MASK[i]),
        .HAS_OD     (OD_MASK[i]),
        .HAS_ANALOG (ANALOG_MASK[i])
      ) u_cell (
        .cfg        (cfg),
        .serial_out (serial_out[i]),
        .other_out  (other_out[i]),
        .pin_level  (pin_in[i]),
        .drive      (drive)
      );

      assign cell_value[i] = drive.drive_value;
      assign cell_oe_n[i]  = drive.drive_oe_n;
      assign cell_din[i]   = drive.digital_in;
    end
  endgenerate

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  // one cycle of latency buys glitch-free pads
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_out_reg    <= '0;
      pin_oe_n_reg   <= '1;
      digital_in_reg <= '0;
    end else begin
      pin_out_reg    <= cell_value;
      pin_oe_n_reg   <= cell_oe_n;
      digital_in_reg <= cell_din;
    end
  end

  assign rd_data    = rd_data_reg;
  assign pin_out    = pin_out_reg;
  assign pin_oe_n   = pin_oe_n_reg;
  assign digital_in = digital_in_reg;
  assign analog_en  = analog_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_read_latch;
    bus_req.re && (bus_req.addr == `PORT_LATCH_OFS);
  endsequence

  sequence s_latch_cleared;
    bus_req.we && (bus_req.addr == `PORT_LATCH_OFS) && (bus_req.wdata == '0);
  endsequence

  a_read_latch_data: assert property (s_read_latch |=>
      rd_data == port_mux_pkg::DATA_W'($past(latch_reg)))
    else $error("read data differ from latch register");

  generate
    for (i = 0; i < NUM_PINS; i = i + 1) begin : g_chk
      localparam bit HS = SERIAL_MASK[i];
      localparam bit HO = OTHER_MASK[i];
      localparam bit HD = OD_MASK[i];

      a_latch_gates_serial: assert property (
          s_latch_cleared ##1 (!other_out[i] || !HO) |=> !pin_out[i])
        else $error("serial output passed a cleared latch");

      a_other_forces_high: assert property (
          !$past(srst) && HO && $past(other_out[i]) |-> pin_out[i])
        else $error("non-serial output did not reach pin");

      a_absent_serial_gate: assert property (
          !$past(srst) && !HS && $past(latch_reg[i]) |-> pin_out[i])
        else $error("absent serial gate not tied high");

      a_absent_other_zero: assert property (
          !$past(srst) && !HO && !$past(latch_reg[i]) |-> !pin_out[i])
        else $error("absent function contributed a high");

      a_no_od_push_pull: assert property (
          !$past(srst) && !HD && ($past(dir_reg[i]) == `PORT_DIR_OUTPUT)
          && !$past(analog_reg[i]) |-> !pin_oe_n[i])
        else $error("pin without open drain select not driven");

      a_od_release_high: assert property (
          !$past(srst) && HD && $past(od_reg[i]) && pin_out[i] |-> pin_oe_n[i])
        else $error("open drain pin drove a high");

      a_analog_blocks_out: assert property (
          !$past(srst) && $past(analog_reg[i]) |-> pin_oe_n[i] && !digital_in[i])
        else $error("analog pin still used digitally");
    end
  endgenerate

endmodule

`default_nettype wire

// ### bench/pad_periph_model.sv
// pad and peripheral-output model on the far side of the port mux
// assumes one clock; levels change only after its rising edge
`default_nettype none

module pad_periph_model (
  input  wire logic       clock,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] ser_cmd,
  input  wire logic [7:0] oth_cmd,
  input  wire logic [7:0] ext_lvl,
  output var  logic [7:0] serial_out,
  output var  logic [7:0] other_out,
  output var  logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    serial_out = 8'h00;
    other_out = 8'h00;
    pin_in = 8'h00;
  end

  // peripherals are clocked units, so their outputs move one edge late
  always @(posedge clock) begin
    serial_out <= ser_cmd;
    other_out <= oth_cmd;
    // a released pad shows the board level, never the stale driven value
    for (int i = 0; i < 8; i++) begin
      pin_in[i] <= pin_oe_n[i] ? ext_lvl[i] : pin_out[i];
    end
  end
endmodule

`default_nettype wire

// ### bench/test_port_output_mux_logic.sv
// self-checking bench for the port output combining block
// assumes the package and the pad model are compiled first
`default_nettype none

module test_port_output_mux_logic;
  timeunit 1ns;
  timeprecision 1ps;
  // pin0 lacks serial, pin1 other, pin2 open drain, pin3 analog
  localparam logic [7:0] SM = 8'hfe;
  localparam logic [7:0] OM = 8'hfd;
  localparam logic [7:0] DM = 8'hfb;
  localparam logic [7:0] AM = 8'hf7;
  logic                   clock;
  logic                   srst;
  port_mux_pkg::reg_req_t bus_req;
  logic [7:0]             rd_data, serial_out, other_out, pin_in;
  logic [7:0]             pin_out, pin_oe_n, digital_in, analog_en;
  logic [7:0]             ser_cmd, oth_cmd, ext_lvl;
  int                     n_fail, samples_checked;
  // latch, serial, other
  logic [23:0] tbl [5] = '{24'hffa500,
                           24'h0fff00,
                           24'h00005a,
                           24'h00ffff,
                           24'hff0000};

  port_output_mux_logic #(.NUM_PINS(8), .SERIAL_MASK(SM), .OTHER_MASK(OM),
    .OD_MASK(DM), .ANALOG_MASK(AM)) i_dut (.clock(clock), .srst(srst),
    .bus_req(bus_req), .rd_data(rd_data), .serial_out(serial_out),
    .other_out(other_out), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .digital_in(digital_in), .analog_en(analog_en));

  pad_periph_model i_pad (.clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ser_cmd(ser_cmd), .oth_cmd(oth_cmd), .ext_lvl(ext_lvl),
    .serial_out(serial_out), .other_out(other_out), .pin_in(pin_in));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] val(input logic [7:0] l, s, o);
    return ((s | ~SM) & l) | (o & OM);
  endfunction

  task automatic chk(input logic [7:0] g, e, input string w);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t %s got %h exp %h", $time, w, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clock);
    bus_req.we <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, e, input string w);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clock);
    bus_req.re <= 1'b0;
    #1;
    chk(rd_data, e, w);
  endtask

  // pin path is one edge behind, pad model one more
  task automatic settle;
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    tally_and_finish;
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    bus_req = '0;
    ser_cmd = 8'h00;
    oth_cmd = 8'h00;
    ext_lvl = 8'h3c;
    n_fail = 0;
    samples_checked = 0;
    srst = 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    rchk(8'h00, 8'h00, "latch rst");
    rchk(8'h04, 8'hff, "dir rst");
    rchk(8'h08, 8'h00, "od rst");
    rchk(8'h0c, AM, "analog rst");
    chk(pin_oe_n, 8'hff, "oe_n rst");
    chk(analog_en, AM, "analog_en rst");
    chk(digital_in, 8'h3c & ~AM, "din analog");
    wr(8'h08, 8'hff);
    rchk(8'h08, DM, "od no select");
    wr(8'h0c, 8'hff);
    rchk(8'h0c, AM, "analog absent");
    wr(8'h14, 8'h55);
    rchk(8'h14, 8'h00, "unmapped");
    $display("test registers done");
    wr(8'h0c, 8'h0f);
    settle;
    chk(digital_in, 8'h38, "din part analog");
    wr(8'h0c, 8'h00);
    settle;
    chk(digital_in, 8'h3c, "din digital");
    rchk(8'h10, 8'h3c, "level");
    $display("test input path done");
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h00);
    foreach (tbl[k]) begin
      wr(8'h00, tbl[k][23:16]);
      ser_cmd <= tbl[k][15:8];
      oth_cmd <= tbl[k][7:0];
      settle;
      chk(pin_out, val(tbl[k][23:16], tbl[k][15:8], tbl[k][7:0]), "mix");
      chk(pin_oe_n, 8'h00, "push-pull");
    end
    $display("test combining done");
    ext_lvl <= 8'hff;
    ser_cmd <= 8'hff;
    oth_cmd <= 8'h00;
    wr(8'h08, 8'hff);
    wr(8'h00, 8'h0f);
    settle;
    chk(pin_oe_n, 8'h0b, "open drain");
    chk(digital_in, 8'h0f, "od level");
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h0f);
    settle;
    chk(pin_oe_n, 8'h07, "analog off");
    wr(8'h04, 8'hff);
    settle;
    chk(pin_oe_n, 8'hff, "input dir");
    $display("test output modes done");
    tally_and_finish;
  end
endmodule

`default_nettype wire
